// >>> inc/buck_regs_pkg.sv
// Package: register map, field layout, reset values and types of the bank
package buck_regs_pkg;

  // ****************************************************************
  // Register indices and bus address
  // ****************************************************************
  localparam logic [6:0] DEVICE_ADDR = 7'h60;
  localparam logic [7:0] OUTPUT2_SELECT_IDX = 8'h01;
  localparam logic [7:0] OUTPUT2_COMMAND_IDX = 8'h03;
  localparam logic [7:0] SYSTEM_FLAGS_IDX = 8'h04;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int GO_BIT = 7;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [2:0] RAMP_RESET = 3'h0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic OFF_RESET = 1'b0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Light-load codes
  localparam logic [1:0] MODE_BY_PIN = 2'h0;
  localparam logic [1:0] MODE_FIXED = 2'h1;
  localparam logic [1:0] MODE_SKIP = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;

  // Voltage code mapping, in millivolts
  localparam logic [10:0] VOUT_BASE_MV = 11'h2a8;
  localparam logic [10:0] VOUT_STEP_MV = 11'h00a;
  localparam logic [6:0] CODE_RESET = 7'h00;
  localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [2:0] ramp_speed;
    logic [1:0] light_load_select;
    logic output2_off;
  } command_type;

  typedef struct packed {
    logic over_temp;
    logic output2_in_regulation;
    logic output1_in_regulation;
  } status_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_INDEX, ST_ACK_INDEX,
    ST_WDATA, ST_ACK_DATA, ST_RDATA, ST_RACK
  } link_state_type;

endpackage : buck_regs_pkg

// >>> src/buck_output2_regs.sv
// Two-wire slave holding the second output's command and status bank
// Notes on behaviour
// RULE_01: Ramp field bits 6:4 steps code once every 2^N switching cycles.
// RULE_02: Light-load field bits 2:1 picks pin, fixed-frequency or pulse skip.
// RULE_03: Command bit 0 set turns the second output off; resets to 0.
// RULE_04: Status bit 2 reads 1 while die is above 125 C.
// RULE_05: Status bit 1 reads 1 while second output is in regulation.
// RULE_06: Status bit 0 reads 1 while first output is in regulation.
// RULE_07: Status bits 7:3 and command bits 7 and 3 have no function.
// RULE_08: Voltage code maps to 0.68 V plus 10 mV per step, to 1.95 V.
// RULE_09: Host sets select bit 7 before the programmed code is applied.
// RULE_10: Update is start, address, index byte, data byte; each acked.
// RULE_11: In paralleled mode the second output's registers are ignored.
// RULE_12: Reserved bits read 0; light-load code 11 leaves mode unchanged.
module buck_output2_regs
  import buck_regs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic sw_cycle_i,
  input wire logic mode_pin_i,
  input wire logic share_mode_i,
  input wire status_type sense_i,
  output logic output2_off_o,
  output logic pulse_skip_o,
  output logic output2_i2c_ctrl_o,
  output logic [10:0] vout2_mv_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_q1;
  logic rst_n;

  // Two stages so release never lands near an edge
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ****************************************************************
  // Link line events
  // ****************************************************************
  logic scl_q;
  logic sda_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire start_seen = scl_i & scl_q & sda_q & ~sda_i;
  wire stop_seen = scl_i & scl_q & ~sda_q & sda_i;

  // ****************************************************************
  // Byte engine
  // ****************************************************************
  link_state_type state;
  link_state_type next_state;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] index;
  logic read_mode;
  logic nack_seen;
  logic next_oe;
  logic [7:0] select2;
  command_type command;
  status_type status;
  logic [7:0] read_data;

  wire byte_done = (bit_cnt == BIT_COUNT_BYTE);
  wire addr_match = (shift[7:1] == DEVICE_ADDR);
  wire write_strobe = (state == ST_WDATA) && scl_fall && byte_done;
  // Paralleled mode: second output's registers take no writes
  wire sel_write = write_strobe && !share_mode_i
    && (index == OUTPUT2_SELECT_IDX); // RULE_11
  wire cmd_write = write_strobe && !share_mode_i
    && (index == OUTPUT2_COMMAND_IDX); // RULE_11
  // Reserved code 11 keeps the earlier mode
  wire mode_keep = (shift[2:1] == MODE_RESERVED); // RULE_12

  // Read mux; reserved bits and unmapped indices read zero
  assign read_data =
    (index == OUTPUT2_SELECT_IDX) ? select2 :
    (index == OUTPUT2_COMMAND_IDX) ?
      {1'b0, command.ramp_speed, 1'b0, command.light_load_select,
       command.output2_off} : // RULE_07
    (index == SYSTEM_FLAGS_IDX) ? {5'h00, status} : // RULE_07
    8'h00;

  // Next-state decode; start always restarts, stop always releases
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_oe = sda_oe_o;
    if (start_seen) begin
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_oe = 1'b0;
    end else if (stop_seen) begin
      next_state = ST_IDLE;
      next_oe = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_INDEX, ST_WDATA: begin
          if (scl_rise && !byte_done) begin
            next_shift = {shift[6:0], sda_i};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && byte_done) begin
            // Ack each byte by pulling the line low; an address byte only when it matches
            next_oe = 1'b1; // RULE_10
            next_bit_cnt = 4'h0;
            if (state == ST_ADDR) begin
              next_state = addr_match ? ST_ACK_ADDR : ST_IDLE;
              next_oe = addr_match;
            end else if (state == ST_INDEX) begin
              next_state = ST_ACK_INDEX;
            end else begin
              next_state = ST_ACK_DATA;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_INDEX, ST_ACK_DATA, ST_RACK: begin
          if (scl_fall) begin
            next_oe = 1'b0;
            next_bit_cnt = 4'h0;
            if ((state == ST_ACK_ADDR && read_mode) ||
                (state == ST_RACK && !nack_seen)) begin
              next_state = ST_RDATA;
              next_shift = read_data;
              next_oe = ~read_data[7];
            end else if (state == ST_RACK) begin
              next_state = ST_IDLE;
            end else if (state == ST_ACK_ADDR) begin
              next_state = ST_INDEX;
            end else begin
              next_state = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_shift = {shift[6:0], 1'b0};
            next_oe = ~shift[6];
            if (bit_cnt == BIT_COUNT_BYTE - 4'h1) begin
              next_state = ST_RACK;
              next_oe = 1'b0;
            end
          end
        end
        ST_IDLE: next_state = ST_IDLE;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      sda_oe_o <= 1'b0;
    end else begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      sda_oe_o <= next_oe;
    end
  end

  // Direction, index and host ack capture
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      read_mode <= 1'b0;
      index <= 8'h00;
      nack_seen <= 1'b0;
    end else begin
      if (state == ST_ADDR && scl_fall && byte_done) read_mode <= shift[0];
      if (state == ST_INDEX && scl_fall && byte_done) index <= shift;
      if (state == ST_RACK && scl_rise) nack_seen <= sda_i;
    end
  end

  // Open-drain pin only ever pulls low
  assign sda_o = 1'b0;

  // ****************************************************************
  // Register bank, written at the falling edge after the data LSB
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      select2 <= SELECT_RESET;
      command <= {RAMP_RESET, MODE_RESET, OFF_RESET};
      status <= STATUS_RESET[2:0];
    end else begin
      if (sel_write) select2 <= shift; // RULE_10
      if (cmd_write) begin
        command.ramp_speed <= shift[6:4]; // RULE_01
        if (!mode_keep) command.light_load_select <= shift[2:1]; // RULE_12
        command.output2_off <= shift[0]; // RULE_03
      end
      status <= sense_i; // RULE_04 RULE_05 RULE_06
    end
  end

  // ****************************************************************
  // Output control and voltage ramp
  // ****************************************************************
  logic [6:0] code;
  logic [6:0] ramp_cnt;
  // Ignored registers in paralleled mode fall back to their defaults
  wire go_applied = select2[GO_BIT] && !share_mode_i; // RULE_09 RULE_11
  wire [6:0] target = select2[6:0];
  wire [6:0] period_last = 7'((8'h01 << command.ramp_speed) - 8'h01);
  wire ramp_tick = sw_cycle_i && (ramp_cnt >= period_last);
  wire mode_skip =
    (command.light_load_select == MODE_BY_PIN) ? mode_pin_i :
    (command.light_load_select == MODE_SKIP); // RULE_02
  wire [10:0] next_vout = VOUT_BASE_MV + 11'(code) * VOUT_STEP_MV; // RULE_08

  // Step one code every 2^N switching cycles toward the target
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      code <= CODE_RESET;
      ramp_cnt <= 7'h00;
    end else if (!go_applied || code == target) begin
      ramp_cnt <= 7'h00;
    end else if (ramp_tick) begin
      ramp_cnt <= 7'h00;
      code <= (code < target) ? code + 7'h01 : code - 7'h01; // RULE_01
    end else if (sw_cycle_i) begin
      ramp_cnt <= ramp_cnt + 7'h01;
    end
  end

  // Registered controls toward the power stage
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      output2_off_o <= OFF_RESET;
      pulse_skip_o <= 1'b0;
      output2_i2c_ctrl_o <= 1'b0;
      vout2_mv_o <= VOUT_BASE_MV;
    end else begin
      output2_off_o <= command.output2_off && !share_mode_i; // RULE_03
      pulse_skip_o <= share_mode_i ? mode_pin_i : mode_skip; // RULE_02
      output2_i2c_ctrl_o <= go_applied;
      vout2_mv_o <= next_vout;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence data_byte_end;
    (state == ST_WDATA) && scl_fall && byte_done && !start_seen
      && !stop_seen;
  endsequence
  sequence ack_held;
    (state == ST_ACK_DATA) && sda_oe_o;
  endsequence

  a_data_ack_drive: assert property ( // RULE_10
    @(posedge clock_i) disable iff (!rst_n)
    data_byte_end |=> ack_held)
    else $error("data byte not acknowledged");
  a_ramp_fast_step: assert property ( // RULE_01
    @(posedge clock_i) disable iff (!rst_n)
    (go_applied && command.ramp_speed == 3'h0 && sw_cycle_i
      && code != target) |=> (code != $past(code)))
    else $error("ramp at speed 0 did not step");
  a_ramp_slow_hold: assert property ( // RULE_01
    @(posedge clock_i) disable iff (!rst_n)
    (go_applied && ramp_cnt == 7'h00 && command.ramp_speed != 3'h0)
      |=> (code == $past(code)))
    else $error("ramp stepped too early");
  a_mode_fixed_out: assert property ( // RULE_02
    @(posedge clock_i) disable iff (!rst_n)
    (command.light_load_select == MODE_FIXED && !share_mode_i)
      |=> !pulse_skip_o)
    else $error("fixed mode shows skip");
  a_off_follows_bit: assert property ( // RULE_03
    @(posedge clock_i) disable iff (!rst_n)
    (!share_mode_i) |=> (output2_off_o == $past(command.output2_off)))
    else $error("off output not following bit");
  a_status_tracks_sense: assert property ( // RULE_04
    @(posedge clock_i) disable iff (!rst_n)
    ##1 (status == $past(sense_i)))
    else $error("status flags stale");
  a_status_read_bits: assert property ( // RULE_05
    @(posedge clock_i) disable iff (!rst_n)
    (index == SYSTEM_FLAGS_IDX) |-> (read_data[7:3] == 5'h00
      && read_data[1] == status.output2_in_regulation
      && read_data[0] == status.output1_in_regulation)) // RULE_06 RULE_07
    else $error("status read bits wrong");
  a_vout_mapping: assert property ( // RULE_08
    @(posedge clock_i) disable iff (!rst_n)
    ##1 (vout2_mv_o == VOUT_BASE_MV + 11'($past(code)) * VOUT_STEP_MV))
    else $error("voltage mapping wrong");
  a_share_ignores: assert property ( // RULE_11
    @(posedge clock_i) disable iff (!rst_n)
    (share_mode_i && write_strobe) |=> (select2 == $past(select2)))
    else $error("write taken in paralleled mode");
  a_reserved_mode: assert property ( // RULE_12
    @(posedge clock_i) disable iff (!rst_n)
    (cmd_write && mode_keep) |=> $stable(command.light_load_select))
    else $error("reserved mode code was stored");

endmodule : buck_output2_regs

// >>> tb/i2c_host_model.sv
// Two-wire bus host model that writes and reads the register bank
module i2c_host_model
  import buck_regs_pkg::*;
(
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Line phases
  // ****************************************************************
  // Lines idle released; the pull-up gives a high level
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // One third of a bit, four clocks, so the device's sampling sees each phase
  task automatic wait_q();
    repeat (4) @(posedge clock_i);
    #1;
  endtask : wait_q

  // Start or repeated start: data falls while clock is high
  task automatic start();
    sda_low_o = 1'b0;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    sda_low_o = 1'b1;
    wait_q();
    scl_o = 1'b0;
    wait_q();
  endtask : start

  // Stop: data rises while clock is high
  task automatic stop();
    sda_low_o = 1'b1;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    sda_low_o = 1'b0;
    wait_q();
  endtask : stop

  // Data changes only while clock is low; level is taken at the end of the high phase
  task automatic put_bit(input logic b, output logic seen);
    sda_low_o = ~b;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    seen = sda_i;
    scl_o = 1'b0;
    wait_q();
  endtask : put_bit

  // Eight bits MSB first, then the ninth bit; last=1 releases the line
  task automatic put_byte(input logic [7:0] b, input logic last,
                          output logic [7:0] got, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], got[i]);
    end
    put_bit(last, nak);
  endtask : put_byte

  // ****************************************************************
  // Register accesses
  // ****************************************************************
  // Single update: start, address, index, one data byte, stop
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] d,
                           output logic [2:0] nak);
    logic [7:0] g;
    start();
    put_byte({DEVICE_ADDR, 1'b0}, 1'b1, g, nak[2]);
    put_byte(idx, 1'b1, g, nak[1]);
    put_byte(d, 1'b1, g, nak[0]);
    stop();
  endtask : write_reg

  // Read ends with a not-acknowledge so the device lets go of the line
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] d);
    logic [7:0] g;
    logic n;
    start();
    put_byte({DEVICE_ADDR, 1'b0}, 1'b1, g, n);
    put_byte(idx, 1'b1, g, n);
    start();
    put_byte({DEVICE_ADDR, 1'b1}, 1'b1, g, n);
    put_byte(8'hff, 1'b1, d, n);
    stop();
  endtask : read_reg
endmodule : i2c_host_model

// >>> tb/tb.sv
// Self-checking bench for the second output command and status bank
module tb;
  import buck_regs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sw = 1'b0;
  logic mode_pin = 1'b0;
  logic share = 1'b0;
  status_type sense = '0;
  logic scl, sda, sda_low, sda_oe, off, skip, ctrl;
  logic [10:0] vout;
  logic [7:0] d;
  logic [2:0] nak;
  logic [1:0] em;
  logic n;
  int err_count = 0;
  int num_checks = 0;

  // Open-drain data line with pull-up
  assign sda = ~(sda_low | sda_oe);
  always #5 clk = ~clk;

  buck_output2_regs buck_output2_regs_i (.clock_i(clk), .rst_b_i(rst_b),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .sw_cycle_i(sw), .mode_pin_i(mode_pin), .share_mode_i(share),
    .sense_i(sense), .output2_off_o(off), .pulse_skip_o(skip),
    .output2_i2c_ctrl_o(ctrl), .vout2_mv_o(vout));

  i2c_host_model i2c_host_model_i (.clock_i(clk), .sda_i(sda),
    .scl_o(scl), .sda_low_o(sda_low));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] mv(input int k);
    return 16'(VOUT_BASE_MV) + 16'(VOUT_STEP_MV) * 16'(k);
  endfunction : mv

  // One-cycle switching pulses, spaced so each is seen alone
  task automatic pulses(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      sw = 1'b1;
      @(posedge clk);
      #1;
      sw = 1'b0;
      repeat (2) @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask : pulses

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    i2c_host_model_i.write_reg(idx, v, nak);
    check(16'(nak), 16'h0000);
    repeat (3) @(posedge clk);
    #1;
  endtask : wr

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // Watchdog sized well above the expected run of about 11.5k cycles
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    $display("BAD t=%0t watchdog expired", $time);
    summarize();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    i2c_host_model_i.read_reg(OUTPUT2_COMMAND_IDX, d);
    check(16'(d), 16'h0000);
    check(16'(vout), mv(0));
    $display("test reset done");
    for (int v = 0; v < 8; v++) begin
      sense = status_type'(v[2:0]);
      i2c_host_model_i.read_reg(SYSTEM_FLAGS_IDX, d);
      check(16'(d), {13'h0000, v[2:0]});
    end
    $display("test status done");
    // All ones: reserved bits and mode code 11 must not land
    wr(OUTPUT2_COMMAND_IDX, 8'hff);
    check(16'(off), 16'h0001);
    i2c_host_model_i.read_reg(OUTPUT2_COMMAND_IDX, d);
    check(16'(d), 16'h0071);
    wr(OUTPUT2_COMMAND_IDX, 8'h00);
    check(16'(off), 16'h0000);
    $display("test command done");
    mode_pin = 1'b1;
    for (int m = 0; m < 4; m++) begin
      em = (m == 3) ? MODE_SKIP : m[1:0];
      wr(OUTPUT2_COMMAND_IDX, {5'h00, m[1:0], 1'b0});
      check(16'(skip), (m == 1) ? 16'h0000 : 16'h0001);
      i2c_host_model_i.read_reg(OUTPUT2_COMMAND_IDX, d);
      check(16'(d), {13'h0000, em, 1'b0});
    end
    $display("test mode done");
    // Ramp of one step per four pulses; without go nothing moves
    wr(OUTPUT2_COMMAND_IDX, 8'h20);
    wr(OUTPUT2_SELECT_IDX, 8'h05);
    pulses(8);
    check(16'(vout), mv(0));
    wr(OUTPUT2_SELECT_IDX, 8'h85);
    check(16'(ctrl), 16'h0001);
    pulses(8);
    check(16'(vout), mv(2));
    pulses(16);
    check(16'(vout), mv(5));
    wr(OUTPUT2_COMMAND_IDX, 8'h00);
    wr(OUTPUT2_SELECT_IDX, 8'hff);
    pulses(122);
    check(16'(vout), mv(127));
    $display("test ramp done");
    share = 1'b1;
    wr(OUTPUT2_COMMAND_IDX, 8'h01);
    check(16'(off), 16'h0000);
    check(16'(ctrl), 16'h0000);
    share = 1'b0;
    $display("test sharing done");
    // Another address must not be acknowledged
    i2c_host_model_i.start();
    i2c_host_model_i.put_byte({7'h61, 1'b0}, 1'b1, d, n);
    i2c_host_model_i.stop();
    check(16'(n), 16'h0001);
    $display("test address done");
    summarize();
  end
endmodule : tb
